// File: core/rcp_dev.sv
// Device end: serial configuration slave, register file and data port.
// Assumes link pins are asynchronous to i_clk_sys; user side is not.
//
// Overview of operation
// - Configuration held in 8-bit registers, 7-bit addressed
// - Each transfer is one 16-bit frame
// - Host sends address MSB first
// - Eighth bit high writes, low reads
// - Data bits follow from D7 to D0
// - Host keeps select low for whole frame
// - Sample input on clock rise, host changes on fall
// - Write commits after D0 is shifted in
// - Registers kept in power-down, any order
// - Every register readable by a read frame
// - Read frame returns addressed register on output
// - Output changes on falling clock edge
// - Host raises select between frames
// - Select high: serial pins ignored, output released
// - Lock output low when locked, or other status
// - Two-bit field selects one of three formats
// - Sync NRZ transmit: capture on bit clock rise
// - Sync NRZ receive: device drives clock and data
// - Manchester receive: zero rises, one falls; transmit: zero falls, one rises
// - Asynchronous: raw data passed, no encoding
`timescale 1ns/1ps
module rcp_dev
   import rcp_pkg::*;
#(
   parameter int REG_COUNT = 128,         // Configuration registers
   parameter int HALF_BIT  = BIT_HALF_CYC // Bit clock half period
)(
   input  wire logic i_clk_sys,       // System clock
   input  wire logic i_reset,         // Synchronous reset, high
   rcp_link_if.dev   lnk,             // Pins toward the host
   input  wire logic i_demod_bit,     // Raw demodulator output
   input  wire logic i_pll_locked,    // Synthesizer lock status
   input  wire logic i_carrier_sense, // Carrier sense status
   output logic      o_mod_bit,       // Symbol to modulator
   output logic      o_mod_strobe,    // New symbol on o_mod_bit
   output logic      o_tx_mode        // Transmit mode selected
);

   localparam int HW = $clog2(HALF_BIT);
   localparam logic [HW-1:0] HC_LAST = HW'(HALF_BIT - 1);
   localparam logic [HW-1:0] HC_MID  = HW'(HALF_BIT / 2);

   // Pin synchronisers
   logic [2:0] sclk_s;
   logic [1:0] sel_s;
   logic [1:0] sdi_s;
   logic [1:0] pin_s;

   // Serial slave state
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [6:0] shin;
   logic [6:0] next_shin;
   logic [6:0] addr_q;
   logic [6:0] next_addr;
   logic       rw_q;
   logic       next_rw;
   logic [7:0] shout;
   logic [7:0] next_shout;
   logic       sdo;
   logic       next_sdo;
   logic       sdo_oe_n;
   logic       next_sdo_oe_n;
   logic [7:0] regs      [REG_COUNT];
   logic [7:0] next_regs [REG_COUNT];

   // Data port state
   logic [HW-1:0] hc;
   logic [HW-1:0] next_hc;
   logic          bclk;
   logic          next_bclk;
   logic          bco;
   logic          next_bco;
   logic          c1;
   logic          next_c1;
   logic          txbit;
   logic          next_txbit;
   logic          mod;
   logic          next_mod;
   logic          stb;
   logic          next_stb;
   logic          pin_d;
   logic          next_pin_d;
   logic          pin_oe_n;
   logic          next_pin_oe_n;
   logic          lock_n;
   logic          next_lock_n;
   logic          txm;

   // Decoded link events and configuration
   logic       sclk_rise;
   logic       sclk_fall;
   logic       sel_act;
   logic [7:0] cfg;
   logic [1:0] fmt;
   logic       is_async;
   logic       is_manch;
   logic       split;
   logic       tgl;
   logic       brise;
   logic       bfall;

   // Two flops on every pin before use
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         sclk_s <= 3'h0;
         sel_s  <= 2'h3;
         sdi_s  <= 2'h0;
         pin_s  <= 2'h3;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], lnk.cfg_sclk};
         sel_s  <= {sel_s[0], lnk.cfg_sel_n};
         sdi_s  <= {sdi_s[0], lnk.cfg_serial_in};
         pin_s  <= {pin_s[0], lnk.radio_data_pin};
      end
   end

   // Edges seen only after the second flop
   assign sclk_rise = sclk_s[1] & ~sclk_s[2];
   assign sclk_fall = ~sclk_s[1] & sclk_s[2];
   assign sel_act   = ~sel_s[1];

   // Serial slave next state
   always_comb
   begin
      next_cnt      = cnt;
      next_shin     = shin;
      next_addr     = addr_q;
      next_rw       = rw_q;
      next_shout    = shout;
      next_sdo      = sdo;
      next_sdo_oe_n = sdo_oe_n;
      next_regs     = regs;
      if (!sel_act)
      begin
         // Idle frame: pins ignored, output released
         next_cnt      = 5'h00;
         next_rw       = 1'b1;
         next_sdo_oe_n = 1'b1;
      end
      else
      begin
         if (sclk_rise && cnt < BIT_END_IDX)
         begin
            next_shin = {shin[5:0], sdi_s[1]};
            next_cnt  = cnt + 5'h01;
            if (cnt == BIT_RW_IDX)
            begin
               // Address complete, direction bit arriving
               next_addr  = shin;
               next_rw    = sdi_s[1];
               next_shout = regs[shin];
            end
            if (cnt == BIT_LAST_IDX && rw_q)
               next_regs[addr_q] = {shin, sdi_s[1]};
         end
         if (sclk_fall && !rw_q && cnt > BIT_RW_IDX)
         begin
            // Read-back, most significant bit first
            next_sdo      = shout[7];
            next_shout    = {shout[6:0], 1'b0};
            next_sdo_oe_n = 1'b0;
         end
      end
   end

   // Serial slave registers; only reset clears the register file
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         cnt      <= 5'h00;
         shin     <= 7'h00;
         addr_q   <= 7'h00;
         rw_q     <= 1'b1;
         shout    <= 8'h00;
         sdo      <= 1'b0;
         sdo_oe_n <= 1'b1;
         for (int i = 0; i < REG_COUNT; i++)
            regs[i] <= CFG_RESET;
      end
      else
      begin
         cnt      <= next_cnt;
         shin     <= next_shin;
         addr_q   <= next_addr;
         rw_q     <= next_rw;
         shout    <= next_shout;
         sdo      <= next_sdo;
         sdo_oe_n <= next_sdo_oe_n;
         regs     <= next_regs;
      end
   end

   // Configuration fields steering the data port
   assign cfg      = regs[CFG_REG_A_ADDR];
   assign fmt      = cfg[FMT_LSB +: 2];
   assign txm      = cfg[TX_MODE_BIT];
   assign split    = cfg[SPLIT_BIT];
   assign is_async = (fmt == FMT_ASYNC);
   assign is_manch = (fmt == FMT_MANCH);
   assign tgl      = (hc == HC_LAST);
   assign brise    = tgl & ~bclk;
   assign bfall    = tgl & bclk;

   // Data port next state
   always_comb
   begin
      next_hc       = tgl ? '0 : hc + HW'(1);
      next_bclk     = tgl ? ~bclk : bclk;
      next_c1       = (bclk && hc == HC_MID) ? i_demod_bit : c1;
      next_txbit    = txbit;
      next_mod      = mod;
      next_stb      = 1'b0;
      next_pin_d    = pin_d;
      next_pin_oe_n = txm | (split & ~is_async);
      // Bit clock stands at format bit 0 in asynchronous mode
      next_bco      = is_async ? fmt[0] : next_bclk;
      // Receive data path
      if (is_async)
         next_pin_d = i_demod_bit;
      else if (bfall)
         next_pin_d = is_manch ? c1 : i_demod_bit;
      // Transmit data path
      if (!txm)
         next_mod = 1'b0;
      else if (is_async)
         next_mod = pin_s[1];
      else if (brise)
      begin
         next_txbit = pin_s[1];
         next_mod   = is_manch ? ~pin_s[1] : pin_s[1];
         next_stb   = 1'b1;
      end
      else if (bfall && is_manch)
      begin
         next_mod = txbit;
         next_stb = 1'b1;
      end
      // Lock pin: status, or receive data when split
      if (split && !is_async && !txm)
         next_lock_n = next_pin_d;
      else if (cfg[LOCK_SEL_BIT])
         next_lock_n = ~i_carrier_sense;
      else
         next_lock_n = ~i_pll_locked;
   end

   // Data port registers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         hc       <= '0;
         bclk     <= 1'b0;
         bco      <= 1'b0;
         c1       <= 1'b0;
         txbit    <= 1'b0;
         mod      <= 1'b0;
         stb      <= 1'b0;
         pin_d    <= 1'b0;
         pin_oe_n <= 1'b1;
         lock_n   <= 1'b1;
         o_tx_mode <= 1'b0;
      end
      else
      begin
         hc       <= next_hc;
         bclk     <= next_bclk;
         bco      <= next_bco;
         c1       <= next_c1;
         txbit    <= next_txbit;
         mod      <= next_mod;
         stb      <= next_stb;
         pin_d    <= next_pin_d;
         pin_oe_n <= next_pin_oe_n;
         lock_n   <= next_lock_n;
         o_tx_mode <= txm;
      end
   end

   // Pins and user outputs, all straight from flops
   assign lnk.cfg_serial_out_d    = sdo;
   assign lnk.cfg_serial_out_oe_n = sdo_oe_n;
   assign lnk.radio_bit_clk       = bco;
   assign lnk.dev_data_d          = pin_d;
   assign lnk.dev_data_oe_n       = pin_oe_n;
   assign lnk.lock_n              = lock_n;
   assign o_mod_bit               = mod;
   assign o_mod_strobe            = stb;

endmodule : rcp_dev

// File: core/rcp_host.sv
// Host end: Avalon-MM command registers driving the serial
// configuration master and the synchronous data pins.
// Assumes device pins are asynchronous to i_clk_sys.
`timescale 1ns/1ps
module rcp_host
   import rcp_pkg::*;
#(
   parameter int SCLK_HALF = SCLK_HALF_CYC // Serial clock half period
)(
   input  wire logic        i_clk_sys,         // System clock
   input  wire logic        i_reset,           // Synchronous reset, high
   rcp_link_if.host         lnk,               // Pins toward the device
   input  wire logic [2:0]  i_avs_address,     // Word index
   input  wire logic        i_avs_read,        // Read request
   input  wire logic        i_avs_write,       // Write request
   input  wire logic [31:0] i_avs_writedata,   // Write data
   output logic      [31:0] o_avs_readdata,    // Read data
   output logic             o_avs_waitrequest  // Stall, high
);

   localparam int TW = $clog2(SCLK_HALF);
   localparam logic [TW-1:0] T_LAST = TW'(SCLK_HALF - 1);

   rcp_hstate_type st, next_st;
   logic [TW-1:0] tmr, next_tmr;
   logic [3:0]  bitn, next_bitn;
   logic [15:0] frm, next_frm;
   logic [15:0] cmd, next_cmd;
   logic [7:0]  rxs, next_rxs;
   logic [7:0]  rd_byte, next_rd_byte;
   logic        sclk, next_sclk;
   logic        sel_n, next_sel_n;
   logic        sdi, next_sdi;
   logic        start, next_start;
   logic        wait_q, next_wait;
   logic [31:0] rdata, next_rdata;
   logic [8:0]  txd, next_txd;
   logic        ld, next_ld;
   logic [7:0]  txsh, next_txsh;
   logic [7:0]  drx, next_drx;
   logic [2:0]  drc, next_drc;
   logic [7:0]  rx_byte, next_rx_byte;
   logic        pd, next_pd;
   logic [1:0]  sdo_s, pin_s, lck_s;
   logic [2:0]  bck_s;
   logic        busy, acc, tdone, brise, bfall;

   // Two flops on every device pin
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         sdo_s <= 2'h3;
         pin_s <= 2'h3;
         lck_s <= 2'h3;
         bck_s <= 3'h0;
      end
      else
      begin
         sdo_s <= {sdo_s[0], lnk.cfg_serial_out};
         pin_s <= {pin_s[0], lnk.radio_data_pin};
         lck_s <= {lck_s[0], lnk.lock_n};
         bck_s <= {bck_s[1:0], lnk.radio_bit_clk};
      end
   end

   assign busy  = (st != RCP_IDLE) | start;
   assign acc   = (i_avs_read | i_avs_write) & wait_q &
                  ~(i_avs_write & i_avs_address == REG_CMD & busy);
   assign tdone = (tmr == T_LAST);
   assign brise = bck_s[1] & ~bck_s[2];
   assign bfall = ~bck_s[1] & bck_s[2];

   // Register slave, one-cycle answer, writes to CMD stall while busy
   always_comb
   begin
      next_wait  = 1'b1;
      next_rdata = rdata;
      next_cmd   = cmd;
      next_txd   = txd;
      next_start = 1'b0;
      next_ld    = 1'b0;
      if (acc)
      begin
         next_wait = 1'b0;
         if (i_avs_read)
         begin
            case (i_avs_address)
               REG_CMD:  next_rdata = {16'h0000, cmd};
               REG_STAT: next_rdata = {16'h0000, rd_byte, 6'h00,
                                       ~lck_s[1], busy};
               REG_TXD:  next_rdata = {23'h000000, txd};
               REG_RXD:  next_rdata = {24'h000000, rx_byte};
               default:  next_rdata = 32'h00000000;
            endcase
         end
         else if (i_avs_address == REG_CMD)
         begin
            next_cmd   = i_avs_writedata[15:0];
            next_start = 1'b1;
         end
         else if (i_avs_address == REG_TXD)
         begin
            next_txd = i_avs_writedata[8:0];
            next_ld  = 1'b1;
         end
      end
   end

   // Serial master: frame is address, direction, data, MSB first
   always_comb
   begin
      next_st      = st;
      next_tmr     = tdone ? '0 : tmr + TW'(1);
      next_bitn    = bitn;
      next_frm     = frm;
      next_rxs     = rxs;
      next_rd_byte = rd_byte;
      next_sclk    = sclk;
      next_sel_n   = sel_n;
      next_sdi     = sdi;
      case (st)
         RCP_IDLE:
         begin
            next_tmr = '0;
            if (start)
            begin
               next_sel_n = 1'b0;
               next_sdi   = cmd[15];
               next_frm   = {cmd[14:0], 1'b0};
               next_bitn  = 4'h0;
               next_st    = RCP_LOW;
            end
         end
         RCP_LOW:
            if (tdone)
            begin
               next_sclk = 1'b1;
               next_rxs  = {rxs[6:0], sdo_s[1]};
               next_st   = RCP_HIGH;
            end
         RCP_HIGH:
            if (tdone)
            begin
               next_sclk = 1'b0;
               if (bitn == HBIT_LAST)
               begin
                  if (!cmd[8])
                     next_rd_byte = rxs;
                  next_st = RCP_TAIL;
               end
               else
               begin
                  next_bitn = bitn + 4'h1;
                  next_sdi  = frm[15];
                  next_frm  = {frm[14:0], 1'b0};
                  next_st   = RCP_LOW;
               end
            end
         RCP_TAIL:
            if (tdone)
            begin
               next_sel_n = 1'b1;
               next_st    = RCP_GAP;
            end
         RCP_GAP:
            if (tdone)
               next_st = RCP_IDLE;
         default:
            next_st = RCP_IDLE;
      endcase
   end

   // Data pins: send on bit clock fall, capture on rise
   always_comb
   begin
      next_txsh    = ld ? txd[7:0] : txsh;
      next_pd      = pd;
      next_drx     = drx;
      next_drc     = drc;
      next_rx_byte = rx_byte;
      if (bfall && txd[TXD_DIR_BIT])
      begin
         next_pd   = txsh[7];
         next_txsh = {txsh[6:0], txsh[7]};
      end
      if (brise && !txd[TXD_DIR_BIT])
      begin
         next_drx = {drx[6:0], pin_s[1]};
         next_drc = drc + 3'h1;
         if (drc == 3'h7)
            next_rx_byte = {drx[6:0], pin_s[1]};
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         st <= RCP_IDLE; tmr <= '0; bitn <= 4'h0; frm <= 16'h0000;
         cmd <= 16'h0000; rxs <= 8'h00; rd_byte <= 8'h00;
         sclk <= 1'b0; sel_n <= 1'b1; sdi <= 1'b0; start <= 1'b0;
         wait_q <= 1'b1; rdata <= 32'h00000000; txd <= 9'h000;
         ld <= 1'b0; txsh <= 8'h00; drx <= 8'h00; drc <= 3'h0;
         rx_byte <= 8'h00; pd <= 1'b0;
      end
      else
      begin
         st <= next_st; tmr <= next_tmr; bitn <= next_bitn;
         frm <= next_frm; cmd <= next_cmd; rxs <= next_rxs;
         rd_byte <= next_rd_byte; sclk <= next_sclk;
         sel_n <= next_sel_n; sdi <= next_sdi; start <= next_start;
         wait_q <= next_wait; rdata <= next_rdata; txd <= next_txd;
         ld <= next_ld; txsh <= next_txsh; drx <= next_drx;
         drc <= next_drc; rx_byte <= next_rx_byte; pd <= next_pd;
      end
   end

   // Outputs straight from flops
   assign lnk.cfg_sclk       = sclk;
   assign lnk.cfg_sel_n      = sel_n;
   assign lnk.cfg_serial_in  = sdi;
   assign lnk.host_data_d    = pd;
   assign lnk.host_data_oe_n = ~txd[TXD_DIR_BIT];
   assign o_avs_readdata     = rdata;
   assign o_avs_waitrequest  = wait_q;

endmodule : rcp_host

// File: core/rcp_link_if.sv
// Pin-level link between the radio port device end and the host end.
// Resolves the shared lines from each driver's active-low enable.
`timescale 1ns/1ps
interface rcp_link_if;
   logic cfg_sclk;
   logic cfg_sel_n;
   logic cfg_serial_in;
   logic cfg_serial_out_d;
   logic cfg_serial_out_oe_n;
   logic cfg_serial_out;
   logic radio_bit_clk;
   logic dev_data_d;
   logic dev_data_oe_n;
   logic host_data_d;
   logic host_data_oe_n;
   logic radio_data_pin;
   logic lock_n;

   // Released lines float high through a pull-up
   assign cfg_serial_out = ~cfg_serial_out_oe_n ? cfg_serial_out_d : 1'b1;
   assign radio_data_pin = ~dev_data_oe_n  ? dev_data_d  :
                           ~host_data_oe_n ? host_data_d : 1'b1;

   modport dev (
      input  cfg_sclk, cfg_sel_n, cfg_serial_in, radio_data_pin,
      output cfg_serial_out_d, cfg_serial_out_oe_n, radio_bit_clk,
      output dev_data_d, dev_data_oe_n, lock_n
   );
   modport host (
      output cfg_sclk, cfg_sel_n, cfg_serial_in,
      output host_data_d, host_data_oe_n,
      input  cfg_serial_out, radio_bit_clk, radio_data_pin, lock_n
   );
endinterface : rcp_link_if

// File: core/rcp_pkg.sv
// Shared constants for the radio configuration and data port.
// Assumes a single 250 MHz system clock on both ends.
package rcp_pkg;

   // Frame layout
   localparam int         ADDR_W       = 7;
   localparam int         DATA_W       = 8;
   localparam int         FRAME_BITS   = 16;
   localparam logic [4:0] BIT_RW_IDX   = 5'h07;
   localparam logic [4:0] BIT_LAST_IDX = 5'h0F;
   localparam logic [4:0] BIT_END_IDX  = 5'h10;
   localparam logic [3:0] HBIT_LAST    = 4'hF;

   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SCLK_HALF_NS  = 50;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BIT_HALF_CYC  = 16;

   // Configuration register A: address, fields, reset value
   localparam logic [6:0] CFG_REG_A_ADDR = 7'h03;
   localparam int         FMT_LSB        = 0;
   localparam int         TX_MODE_BIT    = 2;
   localparam int         LOCK_SEL_BIT   = 3;
   localparam int         SPLIT_BIT      = 4;
   localparam logic [7:0] CFG_RESET      = 8'h00;

   // Data formats
   localparam logic [1:0] FMT_SYNC_NRZ = 2'h0;
   localparam logic [1:0] FMT_ASYNC    = 2'h1;
   localparam logic [1:0] FMT_MANCH    = 2'h2;

   // Host Avalon-MM register map (word index)
   localparam int         AVS_AW    = 3;
   localparam logic [2:0] REG_CMD   = 3'h0;
   localparam logic [2:0] REG_STAT  = 3'h1;
   localparam logic [2:0] REG_TXD   = 3'h2;
   localparam logic [2:0] REG_RXD   = 3'h3;
   localparam int         TXD_DIR_BIT = 8;

   // Host serial engine states
   typedef enum logic [4:0] {
      RCP_IDLE = 5'h01,
      RCP_LOW  = 5'h02,
      RCP_HIGH = 5'h04,
      RCP_TAIL = 5'h08,
      RCP_GAP  = 5'h10
   } rcp_hstate_type;

endpackage : rcp_pkg

// File: testbench/radio_host_config_and_data_port_test.sv
// Bench joining host end and device end over the link interface.
// Assumes the package constants; Avalon master drives the host end.
`timescale 1ns/1ps
module radio_host_config_and_data_port_test;
   import rcp_pkg::*;
   logic        i_clk_sys = 1'h0;
   logic        i_reset = 1'h1;
   logic [2:0]  adr = 3'h0;
   logic        rd = 1'h0;
   logic        wr = 1'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q;
   logic [31:0] rdata;
   logic        waitreq;
   logic        demod = 1'h0;
   logic        locked = 1'h1;
   logic        mbit;
   logic        mstb;
   logic        txm;
   logic        sclk_q = 1'h0;
   logic [1:0]  rx_pat = 2'h0;
   logic [15:0] fi;
   logic [15:0] fo;
   logic [6:0]  ra [3] = '{7'h00, 7'h7F, 7'h11};
   logic [7:0]  rv [3] = '{8'h5A, 8'hC3, 8'h01};
   int          n_mismatch = 0;
   int          n_checks = 0;
   rcp_link_if lnk ();
   rcp_dev i_rcp_dev (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .lnk(lnk.dev), .i_demod_bit(demod), .i_pll_locked(locked),
      .i_carrier_sense(1'h0), .o_mod_bit(mbit), .o_mod_strobe(mstb),
      .o_tx_mode(txm));
   rcp_host i_rcp_host (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .lnk(lnk.host), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(q),
      .o_avs_waitrequest(waitreq));
   rcp_link_asserts #(.HALF_BIT(16)) i_rcp_link_asserts (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .cfg_sclk(lnk.cfg_sclk),
      .cfg_sel_n(lnk.cfg_sel_n), .cfg_serial_in(lnk.cfg_serial_in),
      .cfg_serial_out_d(lnk.cfg_serial_out_d),
      .cfg_serial_out_oe_n(lnk.cfg_serial_out_oe_n),
      .radio_bit_clk(lnk.radio_bit_clk), .dev_data_d(lnk.dev_data_d),
      .dev_data_oe_n(lnk.dev_data_oe_n));
   // Clock
   always #2 i_clk_sys = ~i_clk_sys;
   // Frame capture at serial clock rise, demodulator stimulus
   always @(posedge i_clk_sys)
   begin
      sclk_q <= lnk.cfg_sclk;
      if (!lnk.cfg_sel_n && lnk.cfg_sclk && !sclk_q)
      begin
         fi <= {fi[14:0], lnk.cfg_serial_in};
         fo <= {fo[14:0], lnk.cfg_serial_out};
      end
      demod <= rx_pat[1] ? lnk.radio_bit_clk ^ rx_pat[0] : rx_pat[0];
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // One Avalon transfer, held until waitrequest is low
   task automatic av(input logic [2:0] a, input logic w_en,
                     input logic [31:0] d);
      int k;
      @(posedge i_clk_sys);
      adr <= a;
      wr  <= w_en;
      rd  <= ~w_en;
      wd  <= d;
      k = 0;
      do
      begin
         @(posedge i_clk_sys);
         k++;
      end
      while (waitreq !== 1'h0 && k < 3000);
      if (k >= 3000)
      begin
         n_mismatch++;
         results();
      end
      rdata = q;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask : av
   // One serial frame, then poll until idle
   task automatic cfg(input logic [6:0] a, input logic w_en,
                      input logic [7:0] d);
      int k;
      av(REG_CMD, 1'h1, {16'h0000, a, w_en, d});
      k = 0;
      do
      begin
         av(REG_STAT, 1'h0, 32'h0);
         k++;
      end
      while (rdata[0] !== 1'h0 && k < 400);
      if (k >= 400)
      begin
         n_mismatch++;
         results();
      end
   endtask : cfg
   initial
   begin
      int k;
      logic ok;
      logic [15:0] w;
      logic [15:0] t;
      repeat (6) @(posedge i_clk_sys);
      i_reset <= 1'h0;
      // Let the lock status pass both synchroniser stages
      repeat (4) @(posedge i_clk_sys);
      av(REG_STAT, 1'h0, 32'h0);
      chk(rdata[1], 1'h1, "lock");
      locked <= 1'h0;
      repeat (8) @(posedge i_clk_sys);
      av(REG_STAT, 1'h0, 32'h0);
      chk(rdata[1], 1'h0, "unlock");
      av(3'h5, 1'h1, 32'hFF);
      av(3'h5, 1'h0, 32'h0);
      chk(rdata, 32'h0, "unmapped");
      $display("test lock done");
      cfg(CFG_REG_A_ADDR, 1'h0, 8'h00);
      chk(rdata[15:8], CFG_RESET, "reset value");
      for (int i = 0; i < 3; i++)
      begin
         cfg(ra[i], 1'h1, rv[i]);
         chk(fi, {ra[i], 1'h1, rv[i]}, "write frame");
      end
      for (int i = 2; i >= 0; i--)
      begin
         cfg(ra[i], 1'h0, 8'h00);
         chk(rdata[15:8], rv[i], "read back");
         chk(fo[7:0], rv[i], "read line");
      end
      $display("test registers done");
      cfg(CFG_REG_A_ADDR, 1'h1, 8'h04);
      av(REG_TXD, 1'h1, 32'h000001A5);
      chk(txm, 1'h1, "tx mode");
      k = 0;
      for (int s = 0; s < 24 && k < 3000; k++)
      begin
         @(negedge i_clk_sys);
         if (mstb === 1'h1)
         begin
            w = {w[14:0], mbit};
            s++;
         end
      end
      if (k >= 3000)
      begin
         n_mismatch++;
         results();
      end
      ok = 1'h0;
      for (int r = 0; r < 8; r++)
      begin
         t = {8'hA5, 8'hA5} >> r;
         if (t[7:0] === w[7:0])
            ok = 1'h1;
      end
      chk(w[15:8], w[7:0], "tx repeat");
      chk(ok, 1'h1, "tx byte");
      $display("test transmit done");
      av(REG_TXD, 1'h1, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         cfg(CFG_REG_A_ADDR, 1'h1, {6'h00, i[1], 1'h0});
         rx_pat <= i[1:0];
         repeat (600) @(posedge i_clk_sys);
         av(REG_RXD, 1'h0, 32'h0);
         chk(rdata[7:0], (i == 1 || i == 2) ? 8'hFF : 8'h00, "rx");
      end
      $display("test receive done");
      results();
   end
endmodule : radio_host_config_and_data_port_test

// File: testbench/rcp_link_asserts.sv
// Checker on the link pins between host end and device end.
// Assumes one system clock; inputs are the link interface signals.
`timescale 1ns/1ps
module rcp_link_asserts #(
   parameter int HALF_BIT = 16 // Bit clock half period
)(
   input wire logic i_clk_sys,           // System clock
   input wire logic i_reset,             // Synchronous reset
   input wire logic cfg_sclk,            // Serial clock
   input wire logic cfg_sel_n,           // Select, low active
   input wire logic cfg_serial_in,       // Frame bit to device
   input wire logic cfg_serial_out_d,    // Read-back bit
   input wire logic cfg_serial_out_oe_n, // Read-back enable
   input wire logic radio_bit_clk,       // Bit clock
   input wire logic dev_data_d,          // Device data bit
   input wire logic dev_data_oe_n        // Device data enable
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   logic [4:0] rise_cnt;
   logic       rw_bit;
   logic [7:0] run;
   logic       armed;
   // Rises per frame, latched R/W bit, bit clock run length
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         rise_cnt <= 5'h00;
         rw_bit   <= 1'h1;
         run      <= 8'h00;
         armed    <= 1'h0;
      end
      else
      begin
         if ($fell(cfg_sel_n))
            rise_cnt <= 5'h00;
         else if ($rose(cfg_sclk) && !cfg_sel_n)
            rise_cnt <= rise_cnt + 5'h01;
         if ($rose(cfg_sclk) && rise_cnt == 5'h07)
            rw_bit <= cfg_serial_in;
         run   <= $changed(radio_bit_clk) ? 8'h01 : run + 8'h01;
         armed <= armed | $changed(radio_bit_clk);
      end
   end
   sequence sel_held;
      cfg_sel_n [*8];
   endsequence
   sclk_in_frame_a: assert property ($rose(cfg_sclk) |-> !cfg_sel_n)
      else $error("serial clock rose outside a frame");
   sel_gap_a: assert property ($rose(cfg_sel_n) |-> sel_held)
      else $error("select high time too short");
   sdi_on_fall_a: assert property (
      !cfg_sel_n && $changed(cfg_serial_in) |-> !cfg_sclk)
      else $error("serial input changed while clock high");
   frame_len_a: assert property ($rose(cfg_sel_n) |-> rise_cnt == 5'h10)
      else $error("frame not sixteen clocks");
   read_drive_a: assert property (
      !cfg_serial_out_oe_n |-> rise_cnt >= 5'h08 && !rw_bit)
      else $error("read-back driven outside read data");
   read_start_a: assert property (
      $fell(cfg_serial_out_oe_n) |-> rise_cnt == 5'h08)
      else $error("read-back started at wrong bit");
   sel_release_a: assert property (cfg_sel_n [*4] |-> cfg_serial_out_oe_n)
      else $error("read-back not released");
   sdo_steady_a: assert property (
      cfg_sclk [*5] ##0 !cfg_serial_out_oe_n |-> $stable(cfg_serial_out_d))
      else $error("read-back changed while clock high");
   bit_half_a: assert property (
      armed && $changed(radio_bit_clk) |-> run == HALF_BIT)
      else $error("bit clock half period wrong");
   rx_steady_a: assert property (
      !dev_data_oe_n && radio_bit_clk && $past(radio_bit_clk)
      |-> $stable(dev_data_d))
      else $error("rx data changed while bit clock high");
endmodule : rcp_link_asserts
